//--- bench/rom_to_queue_write_control_bench.sv
`timescale 1ns/1ps
module rom_to_queue_write_control_bench;
	logic ref_clk_in = 1'b0;
	logic reset_in = 1'b1;
	logic queue_full_in = 1'b0;
	logic [7:0] rom_addr;
	logic [31:0] rom_data, q_data;
	logic q_wr, wr_req, busy, waiting, done;
	logic [8:0] n_wr, n_del;
	logic [15:0] stalls;
	logic [2:0] lvl;
	logic [31:0] expect_q[$];
	int fail_count = 0;
	int cmp_count = 0;
	int seed = 55;
	int full_pct = 0;
	logic waited = 1'b0;
	// Small depth so back-pressure reaches the wait state quickly
	rqw_write_ctrl #(.DEPTH(4)) u_dut (.ref_clk_in(ref_clk_in),
		.reset_in(reset_in), .rom_addr_out(rom_addr),
		.rom_data_in(rom_data), .queue_full_in(queue_full_in),
		.queue_wr_req_out(q_wr), .queue_data_out(q_data),
		.wr_req_out(wr_req), .busy_out(busy), .waiting_out(waiting),
		.done_out(done), .words_written_out(n_wr),
		.words_delivered_out(n_del), .stall_cycles_out(stalls),
		.buffer_level_out(lvl));
	rqw_rom_model u_rom (.rom_addr_in(rom_addr), .rom_data_out(rom_data));
	initial begin
		forever #4 ref_clk_in = ~ref_clk_in;
	end
	task automatic check_bit(input logic got, input string what);
		cmp_count++;
		if (got !== 1'b1) begin
			fail_count++;
			$display("[FAIL] %0t %s", $time, what);
		end
	endtask
	task automatic check_word(input logic [31:0] got, input logic [31:0] exp,
		input string what);
		cmp_count++;
		if (got !== exp) begin
			fail_count++;
			$display("[FAIL] %0t %s %h %h", $time, what, got, exp);
		end
	endtask
	task automatic give_verdict();
		$display("compares %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	always @(posedge ref_clk_in) begin
		queue_full_in <= ({$random(seed)} % 100) < full_pct;
		if (waiting === 1'b1)
			waited <= 1'b1;
		if (!reset_in && q_wr === 1'b1) begin
			if (expect_q.size() == 0)
				check_bit(1'b0, "extra queue write");
			else
				check_word(q_data, expect_q.pop_front(), "word");
		end
	end
	// Every ROM word once, in address order
	task automatic load_expect();
		int k;
		expect_q.delete();
		for (k = 0; k < 256; k++)
			expect_q.push_back({8'(k), ~8'(k), 16'hC35A});
	endtask
	// Reset pulse, then the whole ROM must arrive in order
	task automatic run_all(input int pct, input string name);
		int i;
		full_pct = pct;
		@(posedge ref_clk_in) reset_in <= 1'b1;
		@(posedge ref_clk_in) reset_in <= 1'b0;
		load_expect();
		i = 0;
		while ((done !== 1'b1 || expect_q.size() != 0) && i < 20000) begin
			@(posedge ref_clk_in);
			i++;
		end
		// Let the last counter updates settle before reading them
		repeat (2) @(posedge ref_clk_in);
		check_bit(i < 20000, "transfer hung");
		check_word({23'h0, n_wr}, 32'h100, "pushed");
		check_word({23'h0, n_del}, 32'h100, "delivered");
		check_word({29'h0, lvl}, 32'h0, "buffer left");
		$display("test %s ended", name);
	endtask
	initial begin
		repeat (20) @(posedge ref_clk_in);
		check_bit(rom_addr == 8'h00 && wr_req == 1'b0, "idle");
		load_expect();
		reset_in <= 1'b0;
		repeat (60) @(posedge ref_clk_in);
		reset_in <= 1'b1;
		repeat (2) @(posedge ref_clk_in);
		check_bit(rom_addr == 8'h00 && busy == 1'b0, "mid reset");
		$display("test reset ended");
		run_all(0, "free");
		run_all(70, "stalled");
		check_bit(waited, "never waited");
		check_bit(stalls != 16'h0000, "no stall count");
		repeat (30) @(posedge ref_clk_in);
		check_bit(done == 1'b1 && wr_req == 1'b0, "done left");
		reset_in <= 1'b1;
		@(posedge ref_clk_in);
		@(negedge ref_clk_in);
		check_bit(done == 1'b0 && rom_addr == 8'h00, "done reset");
		$display("test done ended");
		give_verdict();
	end
	initial begin
		repeat (50000) @(posedge ref_clk_in);
		fail_count++;
		give_verdict();
	end
endmodule

//--- bench/rqw_rom_model.sv
`timescale 1ns/1ps
module rqw_rom_model (
	input wire logic [7:0] rom_addr_in,
	output logic [31:0] rom_data_out
);
	// No clock or reset: the word follows the address at once
	assign rom_data_out = {rom_addr_in, ~rom_addr_in, 16'hC35A};
endmodule

//--- bench/rqw_write_ctrl_properties.sv
`timescale 1ns/1ps
module rqw_write_ctrl_properties #(
	parameter int ADDR_W = 8
) (
	input wire logic ref_clk_in,
	input wire logic reset_in,
	input wire logic [ADDR_W-1:0] rom_addr_out,
	input wire logic queue_full_in,
	input wire logic queue_wr_req_out,
	input wire logic wr_req_out,
	input wire logic busy_out,
	input wire logic waiting_out,
	input wire logic done_out,
	input wire logic [ADDR_W:0] words_written_out
);
	default clocking @(posedge ref_clk_in); endclocking
	default disable iff (reset_in);
	wire adv = busy_out & ~wr_req_out & ~waiting_out;
	sequence push_s;
		wr_req_out && rom_addr_out != '1;
	endsequence
	sequence step_s;
		push_s ##1 adv;
	endsequence
	idle_on_reset_a: assert property ($fell(reset_in) |->
		rom_addr_out == '0 && !wr_req_out && !busy_out) else $error("not idle");
	leave_idle_a: assert property ($fell(reset_in) |=> wr_req_out)
		else $error("no write after reset");
	write_advance_a: assert property (push_s |=> adv &&
		rom_addr_out == $past(rom_addr_out)) else $error("bad write step");
	addr_step_a: assert property (step_s |=>
		rom_addr_out == ADDR_W'($past(rom_addr_out) + 1'b1))
		else $error("address not stepped");
	adv_next_a: assert property (adv |=>
		(wr_req_out || waiting_out) && !done_out) else $error("bad advance");
	wait_hold_a: assert property (waiting_out |=>
		rom_addr_out == $past(rom_addr_out) && (waiting_out || wr_req_out))
		else $error("bad wait");
	last_done_a: assert property (wr_req_out && rom_addr_out == '1
		|=> done_out && !wr_req_out) else $error("no done after last");
	done_hold_a: assert property (done_out |=> done_out &&
		!wr_req_out && rom_addr_out == '1) else $error("done left");
	no_full_push_a: assert property (queue_full_in |->
		!queue_wr_req_out) else $error("write while full");
	word_push_a: assert property (wr_req_out |=>
		words_written_out == (ADDR_W+1)'($past(words_written_out) + 1'b1))
		else $error("write request not pushed");
endmodule

bind rqw_write_ctrl rqw_write_ctrl_properties #(.ADDR_W(ADDR_W)) u_props (
	.ref_clk_in(ref_clk_in), .reset_in(reset_in),
	.rom_addr_out(rom_addr_out), .queue_full_in(queue_full_in),
	.queue_wr_req_out(queue_wr_req_out), .wr_req_out(wr_req_out),
	.busy_out(busy_out), .waiting_out(waiting_out), .done_out(done_out),
	.words_written_out(words_written_out));

//--- core/rqw_fifo.sv
`timescale 1ns/1ps

module rqw_fifo #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 32
) (
	input wire logic ref_clk_in,
	input wire logic reset_in,
	input wire logic in_valid_in,
	output logic in_ready_out,
	input wire logic [WIDTH-1:0] in_data_in,
	output logic out_valid_out,
	input wire logic out_ready_in,
	output logic [WIDTH-1:0] out_data_out,
	output logic [$clog2(DEPTH):0] level_out
);

	localparam int PW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [PW:0] wr_ptr;
	logic [PW:0] rd_ptr;
	logic push;
	logic pop;

	// ----------------------------------------------------------
	// Flags
	// ----------------------------------------------------------
	// Extra pointer bit separates full from empty without a counter
	assign level_out = wr_ptr - rd_ptr;
	assign in_ready_out = (level_out != (PW+1)'(DEPTH));
	assign out_valid_out = (wr_ptr != rd_ptr);
	assign push = in_valid_in && in_ready_out;
	assign pop = out_valid_out && out_ready_in;
	assign out_data_out = mem[rd_ptr[PW-1:0]];

	// ----------------------------------------------------------
	// Storage and pointers
	// ----------------------------------------------------------
	always_ff @(posedge ref_clk_in) begin
		if (push) begin
			mem[wr_ptr[PW-1:0]] <= in_data_in;
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (reset_in) begin
			wr_ptr <= '0;
		end else if (push) begin
			wr_ptr <= wr_ptr + 1'b1;
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (reset_in) begin
			rd_ptr <= '0;
		end else if (pop) begin
			rd_ptr <= rd_ptr + 1'b1;
		end
	end

endmodule

//--- core/rqw_write_ctrl.sv
`timescale 1ns/1ps
`include "rqw_params.svh"

// Functional notes
// - Reset held high keeps the controller in idle.
// - Idle: write request low, ROM address at the first word.
// - Leave idle for write only when the buffer is not full.
// - Write state raises the write request for the word at the ROM.
// - Address stays put during the write state.
// - Write goes on to advance while the address is below the last.
// - Advance state drops the request and adds one to the address.
// - Write and advance alternate while not full and not last.
// - Full seen in advance sends the controller to wait next edge.
// - Wait holds the address while full; not full returns to write.
// - Write at the last address issues the final write, then done.
// - Done keeps the write request low.
module rqw_write_ctrl #(
	parameter int ADDR_W = `RQW_ADDR_WIDTH,
	parameter int DATA_W = `RQW_DATA_WIDTH,
	parameter int DEPTH = `RQW_BUF_DEPTH,
	parameter logic [ADDR_W-1:0] FIRST_ADDR = `RQW_ADDR_FIRST,
	parameter logic [ADDR_W-1:0] LAST_ADDR = `RQW_ADDR_LAST,
	parameter logic [ADDR_W-1:0] ADDR_STEP = `RQW_ADDR_STEP
) (
	input wire logic ref_clk_in,
	input wire logic reset_in,
	output logic [ADDR_W-1:0] rom_addr_out,
	input wire logic [DATA_W-1:0] rom_data_in,
	input wire logic queue_full_in,
	output logic queue_wr_req_out,
	output logic [DATA_W-1:0] queue_data_out,
	output logic wr_req_out,
	output logic busy_out,
	output logic waiting_out,
	output logic done_out,
	output logic [ADDR_W:0] words_written_out,
	output logic [ADDR_W:0] words_delivered_out,
	output logic [`RQW_STALL_WIDTH-1:0] stall_cycles_out,
	output logic [$clog2(DEPTH):0] buffer_level_out
);

	// ----------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------
	rqw_pkg::rqw_state_t state;
	rqw_pkg::rqw_state_t next_state;

	logic [ADDR_W-1:0] rom_addr;
	logic [ADDR_W-1:0] next_rom_addr;
	logic at_last;
	logic buf_full;
	logic buf_in_ready;
	logic buf_out_valid;
	logic buf_out_ready;
	logic [DATA_W-1:0] buf_out_data;
	logic push;
	logic stage_valid;
	logic [DATA_W-1:0] stage_data;
	logic stage_take;
	logic stage_load;
	logic [ADDR_W:0] words_written;
	logic [ADDR_W:0] words_delivered;
	logic [`RQW_STALL_WIDTH-1:0] stall_cycles;
	logic stall_saturated;

	// ----------------------------------------------------------
	// Elastic buffer
	// ----------------------------------------------------------
	// The buffer's full flag is the full flag the sequencer obeys;
	// it only drops when the queue port drains words, so a stalled
	// queue backs up all the way to the ROM pointer.
	rqw_fifo #(
		.WIDTH(DATA_W),
		.DEPTH(DEPTH)
	) u_buf (
		.ref_clk_in(ref_clk_in),
		.reset_in(reset_in),
		.in_valid_in(push),
		.in_ready_out(buf_in_ready),
		.in_data_in(rom_data_in),
		.out_valid_out(buf_out_valid),
		.out_ready_in(buf_out_ready),
		.out_data_out(buf_out_data),
		.level_out(buffer_level_out)
	);

	assign buf_full = !buf_in_ready;
	assign at_last = (rom_addr == LAST_ADDR);

	// ----------------------------------------------------------
	// Sequencer
	// ----------------------------------------------------------
	always_comb begin
		next_state = state;
		case (state)
			rqw_pkg::RQW_IDLE: begin
				if (!buf_full) begin
					next_state = rqw_pkg::RQW_WRITE;
				end
			end
			rqw_pkg::RQW_WRITE: begin
				if (at_last) begin
					next_state = rqw_pkg::RQW_DONE;
				end else begin
					next_state = rqw_pkg::RQW_ADVANCE;
				end
			end
			rqw_pkg::RQW_ADVANCE: begin
				if (buf_full) begin
					next_state = rqw_pkg::RQW_WAIT;
				end else begin
					next_state = rqw_pkg::RQW_WRITE;
				end
			end
			rqw_pkg::RQW_WAIT: begin
				if (!buf_full) begin
					next_state = rqw_pkg::RQW_WRITE;
				end
			end
			rqw_pkg::RQW_DONE: begin
				next_state = rqw_pkg::RQW_DONE;
			end
			default: begin
				next_state = rqw_pkg::RQW_IDLE;
			end
		endcase
	end

	always_ff @(posedge ref_clk_in) begin
		if (reset_in) begin
			state <= rqw_pkg::RQW_IDLE;
		end else begin
			state <= next_state;
		end
	end

	// ----------------------------------------------------------
	// ROM pointer
	// ----------------------------------------------------------
	// The step is taken on the edge that closes the advance state,
	// so the new word has a full cycle to settle through the
	// unregistered ROM before the next write captures it.
	always_comb begin
		next_rom_addr = rom_addr;
		case (state)
			rqw_pkg::RQW_ADVANCE: begin
				next_rom_addr = rom_addr + ADDR_STEP;
			end
			default: begin
				next_rom_addr = rom_addr;
			end
		endcase
	end

	always_ff @(posedge ref_clk_in) begin
		if (reset_in) begin
			rom_addr <= FIRST_ADDR;
		end else begin
			rom_addr <= next_rom_addr;
		end
	end

	// ROM data arrives combinationally from this address
	assign rom_addr_out = rom_addr;

	// ----------------------------------------------------------
	// Write request
	// ----------------------------------------------------------
	// Only the write state requests; idle, advance, wait and done
	// all hold it low. The write state is entered only with room
	// in the buffer and nothing fills it meanwhile, so no word is
	// dropped.
	assign wr_req_out = (state == rqw_pkg::RQW_WRITE);
	assign push = wr_req_out && buf_in_ready;

	// ----------------------------------------------------------
	// Output stage toward the queue write port
	// ----------------------------------------------------------
	// One registered word: the data pin comes straight from a
	// flip-flop and is held until the queue takes it.
	assign stage_take = stage_valid && !queue_full_in;
	assign stage_load = !stage_valid || stage_take;
	assign buf_out_ready = stage_load;
	assign queue_wr_req_out = stage_take;

	always_ff @(posedge ref_clk_in) begin
		if (reset_in) begin
			stage_valid <= 1'b0;
		end else if (stage_load) begin
			stage_valid <= buf_out_valid;
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (reset_in) begin
			stage_data <= '0;
		end else if (stage_load && buf_out_valid) begin
			stage_data <= buf_out_data;
		end
	end

	assign queue_data_out = stage_data;

	// ----------------------------------------------------------
	// Progress and status
	// ----------------------------------------------------------
	// Word counters are one bit wider than the address so a full pass
	// of the ROM reads back as its true word count.
	always_ff @(posedge ref_clk_in) begin
		if (reset_in) begin
			words_written <= '0;
		end else if (push) begin
			words_written <= words_written + 1'b1;
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (reset_in) begin
			words_delivered <= '0;
		end else if (stage_take) begin
			words_delivered <= words_delivered + 1'b1;
		end
	end

	// Stall count saturates rather than wrapping, so a long hold
	// never looks shorter than it was.
	assign stall_saturated = (stall_cycles == '1);

	always_ff @(posedge ref_clk_in) begin
		if (reset_in) begin
			stall_cycles <= `RQW_STALL_ZERO;
		end else if (state == rqw_pkg::RQW_WAIT && !stall_saturated) begin
			stall_cycles <= stall_cycles + `RQW_STALL_ONE;
		end
	end

	assign words_written_out = words_written;
	assign words_delivered_out = words_delivered;
	assign stall_cycles_out = stall_cycles;
	assign waiting_out = (state == rqw_pkg::RQW_WAIT);
	assign done_out = (state == rqw_pkg::RQW_DONE);
	assign busy_out = (state != rqw_pkg::RQW_IDLE) &&
		(state != rqw_pkg::RQW_DONE);

endmodule

//--- inc/rqw_params.svh
`ifndef RQW_PARAMS_SVH
`define RQW_PARAMS_SVH

// Source ROM geometry
`define RQW_ADDR_WIDTH 8
`define RQW_DATA_WIDTH 32
`define RQW_ADDR_FIRST 8'h00
`define RQW_ADDR_LAST 8'hFF
`define RQW_ADDR_STEP 8'h01

// Elastic buffer between controller and queue port
`define RQW_BUF_DEPTH 32

// Status counters
`define RQW_STALL_WIDTH 16
`define RQW_STALL_ONE 16'h0001
`define RQW_STALL_ZERO 16'h0000

`endif

//--- inc/rqw_pkg.sv
package rqw_pkg;

	typedef enum logic [2:0] {
		RQW_IDLE,
		RQW_WRITE,
		RQW_ADVANCE,
		RQW_WAIT,
		RQW_DONE
	} rqw_state_t;

endpackage
